/* File: design/efc_pkg.sv */
// Purpose: constants shared by the errored-field and flag port block
// Assumes: 32-bit AXI4-Lite data, 8-bit byte addresses
// Notes: flag vectors hold three groups of five, group index = select code
package efc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_MODE    = 8'h00;
    localparam logic [7:0] ADDR_SENS    = 8'h04;
    localparam logic [7:0] ADDR_OVR_VAL = 8'h08;
    localparam logic [7:0] ADDR_OVR_CTL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_CNT     = 8'h14;
    // host index 17, one word per index
    localparam logic [7:0] ADDR_CNT_LO  = 8'h44;

    // counter mode select codes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_CLEAR  = 2'h1;
    localparam logic [1:0] MODE_AUTO   = 2'h2;
    localparam logic [1:0] MODE_HOLD   = 2'h3;

    // flag port group select codes
    localparam logic [1:0] SEL_FF  = 2'h0;
    localparam logic [1:0] SEL_AP  = 2'h1;
    localparam logic [1:0] SEL_ANC = 2'h2;
    localparam logic [1:0] SEL_CTL = 2'h3;

    // positions inside a five-bit group
    localparam int UES_BIT = 4;
    localparam int GRP_W   = 5;
    localparam int FLAG_W  = 15;
    // overwrite words: 15 flags, then validity
    localparam int OVR_FFV_BIT = 15;
    localparam int OVR_APV_BIT = 16;
    localparam int OVR_W       = 17;
    // pending bits: groups 0..2, then validity
    localparam int PEND_FFV = 3;
    localparam int PEND_APV = 4;
    localparam int SENS_W        = 16;
    localparam int SENS_CHKSM_BIT = 15;
    localparam int CNT_W = 24;

    // values after reset
    localparam logic [1:0]  MODE_RST = 2'h0;
    localparam logic [15:0] SENS_RST = 16'h0000;
    // direction synchroniser starts at the idle read level
    localparam logic        DIR_RST  = 1'b1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: design/efc_flag_ctrl.sv */
// Purpose: outgoing flag merge, errored-field counter and flag port
// Assumes: packet timing and checks come from the data path on clk
// Notes: registers over AXI4-Lite; flag port pins synchronised
//
// How it works
// - receive: outgoing UES = incoming UES or invalid
// - no packet: all three UES set
// - missing flag raised per field lacking packet
// - packet present needs header and position
// - 24-bit count of fields with counted flags
// - sensitivity low enables, checksum bit high
// - mode 00 normal 01 clear 10 auto 11 hold
// - clear mode zeroes counter, returns to normal
// - auto mode clears on low-byte read
// - hold mode keeps counter at zero
// - select 00 FF, 01 AP, 10 ANC
// - port write used for next packet only
// - port values beat host overwrite
// - select 11 write sets source and validity
// - read source latched, low at reset
// - read mode drives lines, 11 gives status
// - first low sample releases, later ones latch
// - port write touches only chosen group
// - read data one clock after select sample
// - outgoing validity high unless overwritten
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module efc_flag_ctrl
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        pkt_done,
    input  wire logic        receive_mode,
    input  wire logic        hdr_found,
    input  wire logic        hdr_pos_ok,
    input  wire logic [14:0] in_flags,
    input  wire logic        in_ffv,
    input  wire logic        in_apv,
    input  wire logic [14:0] calc_flags,
    input  wire logic        packet_checksum_error,
    input  wire logic        status_bit,
    input  wire logic        flag_dir,
    input  wire logic [1:0]  flag_sel,
    input  wire logic [4:0]  flag_lines_in,
    output logic [4:0]       flag_lines_out,
    output logic             flag_lines_oe,
    output logic [14:0]      out_flags,
    output logic             full_field_validity,
    output logic             active_picture_validity,
    output logic             missing_packet_flag,
    output logic [23:0]      err_field_count
);
    typedef struct packed {
        logic [1:0]  mode;
        logic [15:0] sens;
        logic [16:0] ovr_val;
        logic [16:0] ovr_ctl;
        logic [23:0] cnt;
        logic        missing;
        logic [14:0] oflags;
        logic        offv;
        logic        oapv;
        logic        read_src;
        logic [4:0]  pend;
        logic [16:0] fp_val;
        logic        dir1;
        logic        dir2;
        logic        dir_q;
        logic [1:0]  sel1;
        logic [1:0]  sel2;
        logic [4:0]  fl1;
        logic [4:0]  fl2;
        logic [4:0]  fl_out;
        logic        fl_oe;
        logic        aw_full;
        logic [7:0]  awaddr;
        logic        w_full;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } efc_state_s;

    efc_state_s s_r;
    efc_state_s s_nxt;

    logic        missing_now;
    logic [14:0] base_flags;
    logic [14:0] host_flags;
    logic [14:0] merged;
    logic        m_ffv;
    logic        m_apv;
    logic        cnt_hit;
    logic        fp_wr;
    logic        wr_do;
    logic        ar_fire;
    logic        rd_cnt_lo;

    function automatic logic [31:0] strb_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction

    // one five-bit group of a flag vector
    function automatic logic [4:0] grp(
        input logic [14:0] v,
        input logic [1:0]  g
    );
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 3; i++)
        begin
            if (g == 2'(i))
                r = v[i*efc_pkg::GRP_W +: efc_pkg::GRP_W];
        end
        return r;
    endfunction

    assign missing_now = !(hdr_found && hdr_pos_ok);

    always_comb
    begin
        base_flags = calc_flags;
        if (receive_mode)
        begin
            base_flags[efc_pkg::UES_BIT] =
                in_flags[efc_pkg::UES_BIT] | ~in_ffv;
            base_flags[efc_pkg::GRP_W + efc_pkg::UES_BIT] =
                in_flags[efc_pkg::GRP_W + efc_pkg::UES_BIT] | ~in_apv;
            base_flags[2*efc_pkg::GRP_W + efc_pkg::UES_BIT] =
                in_flags[2*efc_pkg::GRP_W + efc_pkg::UES_BIT];
        end
        if (missing_now)
        begin
            base_flags[efc_pkg::UES_BIT] = 1'b1;
            base_flags[efc_pkg::GRP_W + efc_pkg::UES_BIT] = 1'b1;
            base_flags[2*efc_pkg::GRP_W + efc_pkg::UES_BIT] = 1'b1;
        end
    end

    assign host_flags = (base_flags & ~s_r.ovr_ctl[14:0])
                      | (s_r.ovr_val[14:0] & s_r.ovr_ctl[14:0]);

    // port values are applied last so they win over host overwrite
    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_merge
            assign merged[g*5 +: 5] = s_r.pend[g]
                ? s_r.fp_val[g*5 +: 5] : host_flags[g*5 +: 5];
        end
    endgenerate

    always_comb
    begin
        m_ffv = 1'b1;
        m_apv = 1'b1;
        if (s_r.ovr_ctl[efc_pkg::OVR_FFV_BIT])
            m_ffv = s_r.ovr_val[efc_pkg::OVR_FFV_BIT];
        if (s_r.ovr_ctl[efc_pkg::OVR_APV_BIT])
            m_apv = s_r.ovr_val[efc_pkg::OVR_APV_BIT];
        if (s_r.pend[efc_pkg::PEND_FFV])
            m_ffv = s_r.fp_val[efc_pkg::OVR_FFV_BIT];
        if (s_r.pend[efc_pkg::PEND_APV])
            m_apv = s_r.fp_val[efc_pkg::OVR_APV_BIT];
    end

    assign cnt_hit = (|(merged & ~s_r.sens[14:0]))
        | (packet_checksum_error & s_r.sens[efc_pkg::SENS_CHKSM_BIT]);
    assign fp_wr     = !s_r.dir2 && !s_r.dir_q;
    assign wr_do     = s_r.aw_full && s_r.w_full && !s_r.bvalid;
    assign ar_fire   = s_axi_arvalid && !s_r.rvalid;
    assign rd_cnt_lo = ar_fire && s_axi_araddr == efc_pkg::ADDR_CNT_LO;

    always_comb
    begin
        s_nxt = s_r;
        // two-stage synchronisers on the flag port pins
        s_nxt.dir1  = flag_dir;
        s_nxt.dir2  = s_r.dir1;
        s_nxt.sel1  = flag_sel;
        s_nxt.sel2  = s_r.sel1;
        s_nxt.fl1   = flag_lines_in;
        s_nxt.fl2   = s_r.fl1;
        s_nxt.dir_q = s_r.dir2;

        s_nxt.fl_oe = s_r.dir2;
        s_nxt.fl_out = 5'h00;
        if (s_r.dir2)
        begin
            if (s_r.sel2 == efc_pkg::SEL_CTL)
                s_nxt.fl_out = {packet_checksum_error, in_apv, in_ffv,
                                status_bit, 1'b0};
            else if (s_r.read_src)
                s_nxt.fl_out = grp(in_flags, s_r.sel2);
            else
                s_nxt.fl_out = grp(s_r.oflags, s_r.sel2);
        end

        // outgoing packet
        if (pkt_done)
        begin
            s_nxt.missing = missing_now;
            s_nxt.oflags  = merged;
            s_nxt.offv    = m_ffv;
            s_nxt.oapv    = m_apv;
            s_nxt.pend    = 5'h00;
        end

        if (fp_wr)
        begin
            unique case (s_r.sel2)
                efc_pkg::SEL_CTL:
                begin
                    s_nxt.read_src = s_r.fl2[4];
                    s_nxt.fp_val[efc_pkg::OVR_APV_BIT] = s_r.fl2[3];
                    s_nxt.fp_val[efc_pkg::OVR_FFV_BIT] = s_r.fl2[2];
                    s_nxt.pend[efc_pkg::PEND_APV] = 1'b1;
                    s_nxt.pend[efc_pkg::PEND_FFV] = 1'b1;
                end
                efc_pkg::SEL_FF:
                begin
                    s_nxt.fp_val[4:0] = s_r.fl2;
                    s_nxt.pend[0] = 1'b1;
                end
                efc_pkg::SEL_AP:
                begin
                    s_nxt.fp_val[9:5] = s_r.fl2;
                    s_nxt.pend[1] = 1'b1;
                end
                efc_pkg::SEL_ANC:
                begin
                    s_nxt.fp_val[14:10] = s_r.fl2;
                    s_nxt.pend[2] = 1'b1;
                end
            endcase
        end

        unique case (s_r.mode)
            efc_pkg::MODE_NORMAL:
            begin
                if (pkt_done && cnt_hit)
                    s_nxt.cnt = s_r.cnt + 24'h000001;
            end
            efc_pkg::MODE_CLEAR:
            begin
                s_nxt.cnt  = 24'h000000;
                s_nxt.mode = efc_pkg::MODE_NORMAL;
            end
            efc_pkg::MODE_AUTO:
            begin
                if (rd_cnt_lo)
                    s_nxt.cnt = {23'h000000, pkt_done && cnt_hit};
                else if (pkt_done && cnt_hit)
                    s_nxt.cnt = s_r.cnt + 24'h000001;
            end
            efc_pkg::MODE_HOLD:
                s_nxt.cnt = 24'h000000;
        endcase

        // write channel
        if (s_axi_awvalid && !s_r.aw_full)
        begin
            s_nxt.aw_full = 1'b1;
            s_nxt.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_full)
        begin
            s_nxt.w_full = 1'b1;
            s_nxt.wdata  = s_axi_wdata;
            s_nxt.wstrb  = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;
        if (wr_do)
        begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = efc_pkg::RESP_OKAY;
            unique case (s_r.awaddr)
                efc_pkg::ADDR_MODE:
                    s_nxt.mode = 2'(strb_merge({30'h0, s_r.mode},
                        s_r.wdata, s_r.wstrb));
                efc_pkg::ADDR_SENS:
                    s_nxt.sens = 16'(strb_merge({16'h0, s_r.sens},
                        s_r.wdata, s_r.wstrb));
                efc_pkg::ADDR_OVR_VAL:
                    s_nxt.ovr_val = 17'(strb_merge({15'h0, s_r.ovr_val},
                        s_r.wdata, s_r.wstrb));
                efc_pkg::ADDR_OVR_CTL:
                    s_nxt.ovr_ctl = 17'(strb_merge({15'h0, s_r.ovr_ctl},
                        s_r.wdata, s_r.wstrb));
                efc_pkg::ADDR_STATUS, efc_pkg::ADDR_CNT,
                efc_pkg::ADDR_CNT_LO:
                    s_nxt.bresp = efc_pkg::RESP_OKAY;
                default:
                    s_nxt.bresp = efc_pkg::RESP_SLVERR;
            endcase
        end

        // read channel
        if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
        if (ar_fire)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = efc_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                efc_pkg::ADDR_MODE:    s_nxt.rdata = {30'h0, s_r.mode};
                efc_pkg::ADDR_SENS:    s_nxt.rdata = {16'h0, s_r.sens};
                efc_pkg::ADDR_OVR_VAL: s_nxt.rdata = {15'h0, s_r.ovr_val};
                efc_pkg::ADDR_OVR_CTL: s_nxt.rdata = {15'h0, s_r.ovr_ctl};
                efc_pkg::ADDR_STATUS:
                    s_nxt.rdata = {28'h0, s_r.read_src, s_r.oapv,
                                   s_r.offv, s_r.missing};
                efc_pkg::ADDR_CNT:     s_nxt.rdata = {8'h0, s_r.cnt};
                efc_pkg::ADDR_CNT_LO:  s_nxt.rdata = {24'h0, s_r.cnt[7:0]};
                default:
                begin
                    s_nxt.rdata = 32'h00000000;
                    s_nxt.rresp = efc_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r      <= '0;
            s_r.mode <= efc_pkg::MODE_RST;
            s_r.sens <= efc_pkg::SENS_RST;
            // cleared stages would look like a write cycle after reset
            s_r.dir1  <= efc_pkg::DIR_RST;
            s_r.dir2  <= efc_pkg::DIR_RST;
            s_r.dir_q <= efc_pkg::DIR_RST;
        end
        else
            s_r <= s_nxt;
    end

    assign s_axi_awready           = !s_r.aw_full;
    assign s_axi_wready            = !s_r.w_full;
    assign s_axi_bvalid            = s_r.bvalid;
    assign s_axi_bresp             = s_r.bresp;
    assign s_axi_arready           = !s_r.rvalid;
    assign s_axi_rvalid            = s_r.rvalid;
    assign s_axi_rdata             = s_r.rdata;
    assign s_axi_rresp             = s_r.rresp;
    assign flag_lines_out          = s_r.fl_out;
    assign flag_lines_oe           = s_r.fl_oe;
    assign out_flags               = s_r.oflags;
    assign full_field_validity     = s_r.offv;
    assign active_picture_validity = s_r.oapv;
    assign missing_packet_flag     = s_r.missing;
    assign err_field_count         = s_r.cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_port_release: assert property (
        $fell(s_r.dir2) |=> !flag_lines_oe ##1 !flag_lines_oe)
        else $error("flag lines not released");
    a_read_latency: assert property (
        s_r.dir2 && s_r.sel2 == efc_pkg::SEL_AP && !s_r.read_src
        |=> flag_lines_oe && flag_lines_out == $past(s_r.oflags[9:5]))
        else $error("read data wrong or late");
    a_mode_return: assert property (
        s_r.mode == efc_pkg::MODE_CLEAR && !wr_do
        |=> err_field_count == 24'h0 && s_r.mode == efc_pkg::MODE_NORMAL)
        else $error("clear mode did not return");
    a_hold_zero: assert property (
        s_r.mode == efc_pkg::MODE_HOLD |=> err_field_count == 24'h0)
        else $error("hold mode counter not zero");
    a_count_step: assert property (
        pkt_done && cnt_hit && s_r.mode == efc_pkg::MODE_NORMAL
        |=> err_field_count == 24'($past(s_r.cnt) + 24'h1))
        else $error("counter did not step");
    a_auto_clear: assert property (
        rd_cnt_lo && !pkt_done && s_r.mode == efc_pkg::MODE_AUTO
        |=> err_field_count == 24'h0)
        else $error("auto clear missed");
    a_missing_flag: assert property (
        pkt_done |=> missing_packet_flag == $past(missing_now))
        else $error("missing flag wrong");
    a_missing_ues: assert property (
        pkt_done && missing_now && s_r.ovr_ctl[14:0] == 15'h0
        && s_r.pend == 5'h00
        |=> out_flags[4] && out_flags[9] && out_flags[14])
        else $error("ues not set for missing packet");
    a_valid_default: assert property (
        pkt_done && !s_r.ovr_ctl[efc_pkg::OVR_FFV_BIT]
        && !s_r.pend[efc_pkg::PEND_FFV] |=> full_field_validity)
        else $error("validity not high by default");
    a_port_wins: assert property (
        pkt_done && s_r.pend[0]
        |=> out_flags[4:0] == $past(s_r.fp_val[4:0]))
        else $error("port value lost to host overwrite");
    a_ctl_write: assert property (
        fp_wr && s_r.sel2 == efc_pkg::SEL_CTL
        |=> s_r.read_src == $past(s_r.fl2[4]))
        else $error("read source not loaded");
    a_group_only: assert property (
        fp_wr && s_r.sel2 == efc_pkg::SEL_FF
        |=> s_r.fp_val[14:5] == $past(s_r.fp_val[14:5]))
        else $error("other flag group changed");
endmodule

/* File: sim/efc_port_model.sv */
// Purpose: flag port controller standing on the far side of the block
// Assumes: the block samples its pins on rising edges of clk
// Notes: lines are released whenever the direction pin is high
`timescale 1ns/1ns
module efc_port_model
(
    input  wire logic       clk,
    output logic            flag_dir,
    output logic [1:0]      flag_sel,
    output logic [4:0]      ctl_lines,
    output logic            ctl_oe,
    input  wire logic [4:0] flag_bus,
    input  wire logic       flag_lines_oe
);
    // idle port: read direction, fixed select, lines left alone
    initial
    begin
        flag_dir  = 1'b1;
        flag_sel  = 2'h0;
        ctl_lines = 5'h0;
        ctl_oe    = 1'b0;
    end

    task automatic port_write(input logic [1:0] s, input logic [4:0] d,
                              output logic oe_seen);
        @(posedge clk);
        flag_dir <= 1'b0;
        flag_sel <= s;
        // wait half a clock at least, and until the block has let go,
        // since its direction pin passes a synchroniser first
        do
            @(negedge clk);
        while (flag_lines_oe);
        @(posedge clk);
        ctl_lines <= d;
        ctl_oe    <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        oe_seen = flag_lines_oe;
        @(posedge clk);
        flag_dir <= 1'b1;
        ctl_oe   <= 1'b0;
        // give the block time to take the lines back
        repeat (4) @(posedge clk);
    endtask

    task automatic port_read(input logic [1:0] s, output logic [4:0] v);
        @(posedge clk);
        flag_sel <= s;
        repeat (3) @(posedge clk);
        @(negedge clk);
        v = flag_bus;
    endtask
endmodule

/* File: sim/test_efc_flag_ctrl.sv */
// Purpose: self-checking bench for efc_flag_ctrl
// Assumes: efc_port_model plays the flag port controller
// Notes: the counter wrap at all ones is too long to reach here
`timescale 1ns/1ns
module test_efc_flag_ctrl;
    logic        clk, resetn, pkt_done, receive_mode, hdr_found, hdr_pos_ok;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, flag_sel, last_resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, in_ffv, in_apv, status_bit;
    logic        packet_checksum_error, flag_dir, flag_lines_oe, ctl_oe;
    logic        full_field_validity, active_picture_validity;
    logic        missing_packet_flag;
    logic [14:0] in_flags, calc_flags, out_flags;
    logic [4:0]  flag_lines_in, flag_lines_out, ctl_lines;
    logic [4:0]  bus_last = 5'h0;
    logic [23:0] err_field_count;
    int          n_fail = 0, cmp_count = 0, cycles = 0;

    efc_flag_ctrl i_dut (.*);
    efc_port_model i_ctl (.clk(clk), .flag_dir(flag_dir),
        .flag_sel(flag_sel), .ctl_lines(ctl_lines), .ctl_oe(ctl_oe),
        .flag_bus(flag_lines_in), .flag_lines_oe(flag_lines_oe));

    // undriven lines wander, both sides driving gives unknown
    assign flag_lines_in = (flag_lines_oe && ctl_oe) ? 5'bx :
        flag_lines_oe ? flag_lines_out : ctl_oe ? ctl_lines : ~bus_last;
    always @(posedge clk) bus_last <= flag_lines_in;

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, done;
        done = 1'b0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!done)
        begin
            @(negedge clk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            last_resp = s_axi_bresp;
            @(posedge clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(negedge clk);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        logic ar_t, done;
        done = 1'b0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!done)
        begin
            @(negedge clk);
            ar_t = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            rd = s_axi_rdata;
            last_resp = s_axi_rresp;
            @(posedge clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic pkt(input logic hf, input logic hp);
        @(posedge clk);
        hdr_found  <= hf;
        hdr_pos_ok <= hp;
        pkt_done   <= 1'b1;
        @(posedge clk);
        pkt_done <= 1'b0;
        @(negedge clk);
    endtask

    task automatic t_reset();
        axi_rd(efc_pkg::ADDR_MODE);
        chk(rd, 32'h0);
        axi_rd(efc_pkg::ADDR_STATUS);
        chk(rd[3], 1'b0);
        axi_rd(8'h30);
        chk(last_resp, efc_pkg::RESP_SLVERR);
        axi_wr(8'h30, 32'h1);
        chk(last_resp, efc_pkg::RESP_SLVERR);
        chk(flag_lines_oe, 1'b1);
    endtask

    task automatic t_count();
        calc_flags <= 15'h0001;
        pkt(1'b1, 1'b1);
        pkt(1'b1, 1'b1);
        axi_rd(efc_pkg::ADDR_CNT);
        chk(rd, 32'h2);
        packet_checksum_error <= 1'b1;
        axi_wr(efc_pkg::ADDR_SENS, 32'h1);
        pkt(1'b1, 1'b1);
        chk(err_field_count, 24'h2);
        axi_wr(efc_pkg::ADDR_SENS, 32'h8001);
        pkt(1'b1, 1'b1);
        chk(err_field_count, 24'h3);
        packet_checksum_error <= 1'b0;
        axi_wr(efc_pkg::ADDR_SENS, 32'h0);
        axi_wr(efc_pkg::ADDR_MODE, {30'h0, efc_pkg::MODE_CLEAR});
        axi_rd(efc_pkg::ADDR_MODE);
        chk(rd, 32'h0);
        chk(err_field_count, 24'h0);
        pkt(1'b1, 1'b1);
        chk(err_field_count, 24'h1);
        axi_wr(efc_pkg::ADDR_MODE, {30'h0, efc_pkg::MODE_AUTO});
        pkt(1'b1, 1'b1);
        pkt(1'b1, 1'b1);
        axi_rd(efc_pkg::ADDR_CNT_LO);
        chk(rd, 32'h3);
        axi_rd(efc_pkg::ADDR_CNT);
        chk(rd, 32'h0);
        pkt(1'b1, 1'b1);
        chk(err_field_count, 24'h1);
        axi_wr(efc_pkg::ADDR_MODE, {30'h0, efc_pkg::MODE_HOLD});
        chk(err_field_count, 24'h0);
        pkt(1'b1, 1'b1);
        chk(err_field_count, 24'h0);
        axi_wr(efc_pkg::ADDR_MODE, {30'h0, efc_pkg::MODE_NORMAL});
        pkt(1'b1, 1'b1);
        chk(err_field_count, 24'h1);
    endtask

    task automatic t_ues();
        calc_flags   <= 15'h0;
        receive_mode <= 1'b1;
        in_flags     <= 15'h0010;
        in_apv       <= 1'b0;
        pkt(1'b1, 1'b1);
        chk(out_flags & 15'h4210, 15'h0210);
        chk({full_field_validity, active_picture_validity}, 2'h3);
        in_flags <= 15'h0;
        in_apv   <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            pkt(i != 1, i != 2);
            chk(missing_packet_flag, i inside {1, 2});
            chk(out_flags & 15'h4210,
                (i inside {1, 2}) ? 15'h4210 : 15'h0);
        end
        receive_mode <= 1'b0;
    endtask

    task automatic t_port();
        logic [14:0] e;
        logic [4:0]  v;
        logic        oe;
        calc_flags <= 15'h1ce0;
        axi_wr(efc_pkg::ADDR_OVR_VAL, 32'h1);
        axi_wr(efc_pkg::ADDR_OVR_CTL, 32'h1);
        for (int s = 0; s < 3; s++)
        begin
            e = (15'h1ce1 & ~(15'h1f << 5 * s)) | (15'h0a << 5 * s);
            i_ctl.port_write(2'(s), 5'h0a, oe);
            chk(oe, 1'b0);
            pkt(1'b1, 1'b1);
            chk(out_flags, e);
        end
        pkt(1'b1, 1'b1);
        chk(out_flags, 15'h1ce1);
        i_ctl.port_write(efc_pkg::SEL_CTL, 5'h10, oe);
        pkt(1'b1, 1'b1);
        chk({active_picture_validity, full_field_validity}, 2'h0);
        axi_rd(efc_pkg::ADDR_STATUS);
        chk(rd[3], 1'b1);
        in_flags   <= 15'h2b5a;
        in_ffv     <= 1'b0;
        status_bit <= 1'b1;
        packet_checksum_error <= 1'b1;
        pkt(1'b1, 1'b1);
        chk({active_picture_validity, full_field_validity}, 2'h3);
        for (int s = 0; s < 3; s++)
        begin
            i_ctl.port_read(2'(s), v);
            chk(v, 5'(15'h2b5a >> 5 * s));
        end
        i_ctl.port_read(efc_pkg::SEL_CTL, v);
        chk(v[3:1], 3'b101);
        i_ctl.port_write(efc_pkg::SEL_CTL, 5'h00, oe);
        i_ctl.port_read(efc_pkg::SEL_AP, v);
        chk(v, 5'h07);
        i_ctl.port_read(efc_pkg::SEL_CTL, v);
        chk({v[4], v[1]}, 2'h3);
    endtask

    initial
    begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, pkt_done, receive_mode, hdr_found, hdr_pos_ok,
         packet_checksum_error, status_bit} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, in_flags, calc_flags} = '0;
        {in_ffv, in_apv} = 2'h3;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_count();
        t_ues();
        t_port();
        give_verdict();
    end
endmodule
